// File: verilog/multi_speed_regs.vh
// Register map, field positions, reset values and limits of the multi-speed selector.
// Assumes inclusion by bare name from every design file; definitions only.
`ifndef MULTI_SPEED_REGS_VH
`define MULTI_SPEED_REGS_VH

// ==========================================================================
// Register byte offsets
`define MS_CONFIG_OFS       12'h000
`define MS_TMAP0_OFS        12'h004
`define MS_TMAP1_OFS        12'h008
`define MS_TMAP2_OFS        12'h00C
`define MS_LUT_LO_OFS       12'h010
`define MS_LUT_HI_OFS       12'h014
`define MS_STATUS_OFS       12'h018
`define MS_FREQ_OFS         12'h01C
`define MS_PRESET_BASE      12'h040
`define MS_PRESET_MASK      12'hFC0

// ==========================================================================
// Configuration register fields
`define MS_CFG_OPMODE_LSB   0
`define MS_CFG_REMOTE_LSB   4
`define MS_CFG_COMP_BIT     8
`define MS_CFG_PWRITE_LSB   10
`define MS_CFG_UGROUP_LSB   16
`define MS_CONFIG_RST       32'h00000000
`define MS_OPMODE_EXT       4'h3
`define MS_OPMODE_COMBINED  4'h4

// ==========================================================================
// Terminal function codes and selector reset values
`define MS_FUNC_LOW         8'h00
`define MS_FUNC_MID         8'h01
`define MS_FUNC_HIGH        8'h02
`define MS_FUNC_EXT         8'h08
`define MS_TMAP0_RST        32'hFF020100
`define MS_TMAP_RST         32'hFFFFFFFF

// ==========================================================================
// Combination table reset value, one nibble per {ext,high,mid,low} code
`define MS_LUT_LO_RST       32'h6540312F
`define MS_LUT_HI_RST       32'hEDCBA987
`define MS_IDX_NONE         4'hF

// ==========================================================================
// Frequencies in 0.1 Hz units
`define MS_FREQ_MAX         16'h0FA0
`define MS_NOT_SELECTED     16'h270F
`define MS_HIGH_RST         16'h0258
`define MS_MID_RST          16'h012C
`define MS_LOW_RST          16'h0064

`endif

// File: verilog/preset_bank.v
// Flip-flop storage for the fifteen speed presets, flattened for the selector.
// Assumes writes arrive already checked for range and permission.
`timescale 1ns/10ps
`include "multi_speed_regs.vh"

module preset_bank #(
    parameter N = 15
) (
    // Clock and reset
    input  wire              clk,
    input  wire              rst_n,
    // Write port
    input  wire              wr_en,
    input  wire [3:0]        wr_idx,
    input  wire [15:0]       wr_data,
    // All presets, entry i at bits [16*i+15:16*i]
    output wire [16*N-1:0]   preset_flat
);

    reg [15:0] preset_ff [0:N-1];
    integer    i;

    // Initial values: high, middle, low, then extended speeds not selected
    function [15:0] init_value;
        input integer k;
        begin
            case (k)
                0: begin
                    init_value = `MS_HIGH_RST;
                end
                1: begin
                    init_value = `MS_MID_RST;
                end
                2: begin
                    init_value = `MS_LOW_RST;
                end
                default: begin
                    init_value = `MS_NOT_SELECTED;
                end
            endcase
        end
    endfunction

    // ==========================================================================
    // Storage
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (i = 0; i < N; i = i + 1) begin
                preset_ff[i] <= init_value(i);
            end
        end else if (wr_en) begin
            preset_ff[wr_idx] <= wr_data;
        end
    end

    genvar g;
    generate
        for (g = 0; g < N; g = g + 1) begin : flat_g
            assign preset_flat[16*g+15:16*g] = preset_ff[g];
        end
    endgenerate

endmodule

// File: verilog/terminal_mapper.v
// Routes physical input terminals to speed-select functions by selector codes.
// Assumes terminal levels are already synchronous to the clock.
`timescale 1ns/10ps
`include "multi_speed_regs.vh"

module terminal_mapper #(
    parameter TERMS     = 12,
    parameter EXT_TERMS = 9
) (
    // Terminal levels and their function codes, 8 bits per terminal
    input  wire [TERMS-1:0]   term_in,
    input  wire [8*TERMS-1:0] func_flat,
    // Resolved select functions
    output wire               low_sel,
    output wire               mid_sel,
    output wire               high_sel,
    output wire               ext_sel
);

    wire [TERMS-1:0] low_hit;
    wire [TERMS-1:0] mid_hit;
    wire [TERMS-1:0] high_hit;
    wire [TERMS-1:0] ext_hit;

    // True when terminal is on and carries the given code
    function is_hit;
        input       level;
        input [7:0] code;
        input [7:0] want;
        begin
            is_hit = level & (code == want);
        end
    endfunction

    // ==========================================================================
    // Per-terminal decode; several terminals on one code act as a wired OR
    genvar t;
    generate
        for (t = 0; t < TERMS; t = t + 1) begin : term_g
            assign low_hit[t]  = is_hit(term_in[t], func_flat[8*t+7:8*t], `MS_FUNC_LOW);
            assign mid_hit[t]  = is_hit(term_in[t], func_flat[8*t+7:8*t], `MS_FUNC_MID);
            assign high_hit[t] = is_hit(term_in[t], func_flat[8*t+7:8*t], `MS_FUNC_HIGH);
            // Only the lower terminals accept the extension code
            assign ext_hit[t]  = (t < EXT_TERMS) &
                                 is_hit(term_in[t], func_flat[8*t+7:8*t], `MS_FUNC_EXT);
        end
    endgenerate

    assign low_sel  = |low_hit;
    assign mid_sel  = |mid_hit;
    assign high_sel = |high_hit;
    assign ext_sel  = |ext_hit;

endmodule

// File: verilog/multi_speed_frequency_selector.v
// Multi-speed frequency selector: APB registers, terminal routing, speed table
// and frequency source arbitration for a drive's running frequency command.
// Assumes terminal, jog and analog inputs are synchronous to sys_clk.
//
// The APB slave port and the address map were left to the implementer.
`timescale 1ns/10ps
`include "multi_speed_regs.vh"

module multi_speed_frequency_selector #(
    parameter TERMS     = 12,
    parameter EXT_TERMS = 9,
    parameter N_PRESETS = 15
) (
    // Clock and reset
    input  wire               sys_clk,
    input  wire               reset_n,
    // APB slave
    input  wire [11:0]        paddr,
    input  wire               psel,
    input  wire               penable,
    input  wire               pwrite,
    input  wire [31:0]        pwdata,
    output reg  [31:0]        prdata,
    output wire               pready,
    output wire               pslverr,
    // Contact input terminals
    input  wire [TERMS-1:0]   term_in,
    // Other frequency sources
    input  wire               jog_active,
    input  wire [15:0]        jog_freq,
    input  wire               term4_active,
    input  wire [15:0]        term4_freq,
    input  wire [15:0]        term2_freq,
    input  wire [16:0]        comp_offset,
    // Frequency command
    output wire [15:0]        freq_cmd,
    output wire [1:0]         freq_source,
    output wire               multi_speed_active,
    // Remote setting signals
    output wire               remote_accel,
    output wire               remote_decel,
    output wire               remote_clear
);

    // Register kinds returned by the address decoder
    localparam K_CONFIG = 4'h0;
    localparam K_TMAP0  = 4'h1;
    localparam K_TMAP1  = 4'h2;
    localparam K_TMAP2  = 4'h3;
    localparam K_LUT_LO = 4'h4;
    localparam K_LUT_HI = 4'h5;
    localparam K_STATUS = 4'h6;
    localparam K_FREQ   = 4'h7;
    localparam K_PRESET = 4'h8;
    localparam K_NONE   = 4'hF;

    // Frequency source codes
    localparam SRC_JOG   = 2'h0;
    localparam SRC_MULTI = 2'h1;
    localparam SRC_T4    = 2'h2;
    localparam SRC_T2    = 2'h3;

    // ==========================================================================
    // Reset release
    reg rst_meta_ff;
    reg rst_sync_ff;
    wire rst_n = rst_sync_ff;

    // Deassertion is synchronised so no flop leaves reset on a different edge
    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_meta_ff <= 1'b0;
            rst_sync_ff <= 1'b0;
        end else begin
            rst_meta_ff <= 1'b1;
            rst_sync_ff <= rst_meta_ff;
        end
    end

    // ==========================================================================
    // Decoding helpers
    function [3:0] reg_kind;
        input [11:0] a;
        begin
            case (a)
                `MS_CONFIG_OFS: begin
                    reg_kind = K_CONFIG;
                end
                `MS_TMAP0_OFS: begin
                    reg_kind = K_TMAP0;
                end
                `MS_TMAP1_OFS: begin
                    reg_kind = K_TMAP1;
                end
                `MS_TMAP2_OFS: begin
                    reg_kind = K_TMAP2;
                end
                `MS_LUT_LO_OFS: begin
                    reg_kind = K_LUT_LO;
                end
                `MS_LUT_HI_OFS: begin
                    reg_kind = K_LUT_HI;
                end
                `MS_STATUS_OFS: begin
                    reg_kind = K_STATUS;
                end
                `MS_FREQ_OFS: begin
                    reg_kind = K_FREQ;
                end
                default: begin
                    // Fifteen preset words; the sixteenth slot is a hole
                    if (((a & `MS_PRESET_MASK) == `MS_PRESET_BASE) &&
                        (a[5:2] != 4'hF) && (a[1:0] == 2'b00)) begin
                        reg_kind = K_PRESET;
                    end else begin
                        reg_kind = K_NONE;
                    end
                end
            endcase
        end
    endfunction

    // A preset write is refused for range or permission reasons only;
    // run state and the parameter write select play no part
    function preset_reject;
        input [3:0]  idx;
        input [31:0] data;
        input [15:0] ugroup;
        begin
            if (data[31:16] != 16'h0000) begin
                preset_reject = 1'b1;
            end else if (idx < 4'h3) begin
                preset_reject = (data[15:0] > `MS_FREQ_MAX);
            end else begin
                preset_reject = (ugroup != 16'h0000) ||
                                ((data[15:0] > `MS_FREQ_MAX) &&
                                 (data[15:0] != `MS_NOT_SELECTED));
            end
        end
    endfunction

    // Slice one preset out of the flattened bank
    function [15:0] preset_at;
        input [16*N_PRESETS-1:0] flat;
        input [3:0]              idx;
        begin
            preset_at = flat[{idx, 4'h0} +: 16];
        end
    endfunction

    // ==========================================================================
    // Registers written by software
    reg  [31:0] config_ff;
    reg  [31:0] tmap0_ff;
    reg  [31:0] tmap1_ff;
    reg  [31:0] tmap2_ff;
    reg  [31:0] lut_lo_ff;
    reg  [31:0] lut_hi_ff;

    wire [3:0]  acc_kind   = reg_kind(paddr);
    wire [3:0]  acc_idx    = paddr[5:2];
    wire        access     = psel & penable;
    wire        wr_go      = access & pwrite;
    wire [3:0]  opmode     = config_ff[`MS_CFG_OPMODE_LSB +: 4];
    wire [3:0]  remote_sel = config_ff[`MS_CFG_REMOTE_LSB +: 4];
    wire        comp_on    = config_ff[`MS_CFG_COMP_BIT];
    wire [15:0] ugroup     = config_ff[`MS_CFG_UGROUP_LSB +: 16];
    wire        preset_bad = preset_reject(acc_idx, pwdata, ugroup);
    wire        preset_wr  = wr_go & (acc_kind == K_PRESET) & ~preset_bad;

    // Writes land at the access edge; zero wait states
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            config_ff <= `MS_CONFIG_RST;
            tmap0_ff  <= `MS_TMAP0_RST;
            tmap1_ff  <= `MS_TMAP_RST;
            tmap2_ff  <= `MS_TMAP_RST;
            lut_lo_ff <= `MS_LUT_LO_RST;
            lut_hi_ff <= `MS_LUT_HI_RST;
        end else if (wr_go) begin
            case (acc_kind)
                K_CONFIG: begin
                    config_ff <= pwdata;
                end
                K_TMAP0: begin
                    tmap0_ff <= pwdata;
                end
                K_TMAP1: begin
                    tmap1_ff <= pwdata;
                end
                K_TMAP2: begin
                    tmap2_ff <= pwdata;
                end
                K_LUT_LO: begin
                    lut_lo_ff <= pwdata;
                end
                K_LUT_HI: begin
                    lut_hi_ff <= pwdata;
                end
                default: begin
                    config_ff <= config_ff;
                end
            endcase
        end
    end

    // ==========================================================================
    // Preset storage and terminal routing
    wire [16*N_PRESETS-1:0] preset_flat;
    wire                    low_sel;
    wire                    mid_sel;
    wire                    high_sel;
    wire                    ext_sel;

    preset_bank #(
        .N           (N_PRESETS)
    ) u_preset_bank (
        .clk         (sys_clk),
        .rst_n       (rst_n),
        .wr_en       (preset_wr),
        .wr_idx      (acc_idx),
        .wr_data     (pwdata[15:0]),
        .preset_flat (preset_flat)
    );

    terminal_mapper #(
        .TERMS       (TERMS),
        .EXT_TERMS   (EXT_TERMS)
    ) u_terminal_mapper (
        .term_in     (term_in),
        .func_flat   ({tmap2_ff, tmap1_ff, tmap0_ff}),
        .low_sel     (low_sel),
        .mid_sel     (mid_sel),
        .high_sel    (high_sel),
        .ext_sel     (ext_sel)
    );

    // ==========================================================================
    // Speed selection
    wire [3:0]  sel_code  = {ext_sel, high_sel, mid_sel, low_sel};
    wire [63:0] lut       = {lut_hi_ff, lut_lo_ff};
    wire [3:0]  lut_entry = lut[{sel_code, 2'b00} +: 4];
    reg  [3:0]  fallback_idx;
    reg  [3:0]  nxt_sel_idx;

    // Lowest-ranked basic input wins; extension alone falls to the low preset
    always @* begin
        if (low_sel) begin
            fallback_idx = 4'h2;
        end else if (mid_sel) begin
            fallback_idx = 4'h1;
        end else if (high_sel) begin
            fallback_idx = 4'h0;
        end else if (ext_sel) begin
            fallback_idx = 4'h2;
        end else begin
            fallback_idx = `MS_IDX_NONE;
        end
    end

    // Table entry wins unless its preset is marked not selected
    always @* begin
        nxt_sel_idx = `MS_IDX_NONE;
        if (lut_entry != `MS_IDX_NONE) begin
            if (preset_at(preset_flat, lut_entry) != `MS_NOT_SELECTED) begin
                nxt_sel_idx = lut_entry;
            end else begin
                nxt_sel_idx = fallback_idx;
            end
        end
    end

    // No selection reads as not selected, never past the end of the bank
    wire [15:0] sel_freq  = (nxt_sel_idx == `MS_IDX_NONE) ? `MS_NOT_SELECTED :
                            preset_at(preset_flat, nxt_sel_idx);
    wire        mode_ok   = (opmode == `MS_OPMODE_EXT) ||
                            (opmode == `MS_OPMODE_COMBINED);
    wire        remote_on = (remote_sel != 4'h0);
    wire        multi_ok  = mode_ok & ~remote_on &
                            (sel_freq != `MS_NOT_SELECTED);

    // ==========================================================================
    // Compensation and source arbitration
    wire [17:0] comp_sum = {2'b00, sel_freq} + {comp_offset[16], comp_offset};
    reg  [15:0] multi_freq;
    reg  [15:0] nxt_freq;
    reg  [1:0]  nxt_source;

    // Saturate so a negative trim cannot wrap into a huge command
    always @* begin
        if (!comp_on) begin
            multi_freq = sel_freq;
        end else if (comp_sum[17]) begin
            multi_freq = 16'h0000;
        end else if (comp_sum[16:0] > {1'b0, `MS_FREQ_MAX}) begin
            multi_freq = `MS_FREQ_MAX;
        end else begin
            multi_freq = comp_sum[15:0];
        end
    end

    always @* begin
        if (jog_active) begin
            nxt_freq   = jog_freq;
            nxt_source = SRC_JOG;
        end else if (multi_ok) begin
            nxt_freq   = multi_freq;
            nxt_source = SRC_MULTI;
        end else if (term4_active) begin
            nxt_freq   = term4_freq;
            nxt_source = SRC_T4;
        end else begin
            nxt_freq   = term2_freq;
            nxt_source = SRC_T2;
        end
    end

    // ==========================================================================
    // Registered outputs
    reg  [15:0] freq_cmd_ff;
    reg  [1:0]  source_ff;
    reg         multi_ff;
    reg  [3:0]  sel_idx_ff;
    reg  [3:0]  sel_code_ff;
    reg  [2:0]  remote_ff;

    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            freq_cmd_ff <= 16'h0000;
            source_ff   <= SRC_T2;
            multi_ff    <= 1'b0;
            sel_idx_ff  <= `MS_IDX_NONE;
            sel_code_ff <= 4'h0;
            remote_ff   <= 3'h0;
        end else begin
            freq_cmd_ff <= nxt_freq;
            source_ff   <= nxt_source;
            multi_ff    <= multi_ok & ~jog_active;
            sel_idx_ff  <= nxt_sel_idx;
            sel_code_ff <= sel_code;
            // Select inputs double as remote accel, decel, clear
            remote_ff   <= remote_on ? {high_sel, mid_sel, low_sel} : 3'h0;
        end
    end

    assign freq_cmd           = freq_cmd_ff;
    assign freq_source        = source_ff;
    assign multi_speed_active = multi_ff;
    assign remote_accel       = remote_ff[2];
    assign remote_decel       = remote_ff[1];
    assign remote_clear       = remote_ff[0];

    // ==========================================================================
    // APB read path: data captured in setup, shown through the access phase
    reg [31:0] nxt_prdata;

    always @* begin
        case (acc_kind)
            K_CONFIG: begin
                nxt_prdata = config_ff;
            end
            K_TMAP0: begin
                nxt_prdata = tmap0_ff;
            end
            K_TMAP1: begin
                nxt_prdata = tmap1_ff;
            end
            K_TMAP2: begin
                nxt_prdata = tmap2_ff;
            end
            K_LUT_LO: begin
                nxt_prdata = lut_lo_ff;
            end
            K_LUT_HI: begin
                nxt_prdata = lut_hi_ff;
            end
            K_STATUS: begin
                nxt_prdata = {20'h00000, sel_code_ff, 1'b0, multi_ff, source_ff, sel_idx_ff};
            end
            K_FREQ: begin
                nxt_prdata = {16'h0000, freq_cmd_ff};
            end
            K_PRESET: begin
                nxt_prdata = {16'h0000, preset_at(preset_flat, acc_idx)};
            end
            default: begin
                nxt_prdata = 32'h00000000;
            end
        endcase
    end

    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            prdata <= 32'h00000000;
        end else if (psel & ~penable & ~pwrite) begin
            prdata <= nxt_prdata;
        end
    end

    assign pready  = 1'b1;
    assign pslverr = access & ((acc_kind == K_NONE) |
                               (pwrite & (acc_kind == K_PRESET) & preset_bad));

endmodule

// File: testbench/msfs_chk.sv
// Assertions on the selector's ports: source priority, pass-through, APB errors.
// Assumes a bind from the bench top; one clock domain.
`timescale 1ns/10ps
module msfs_chk (
    // Clock, reset, APB
    input wire        sys_clk,
    input wire        reset_n,
    input wire        psel,
    input wire        penable,
    input wire        pslverr,
    // Sources and results
    input wire        jog_active,
    input wire [15:0] jog_freq,
    input wire        term4_active,
    input wire [15:0] term4_freq,
    input wire [15:0] term2_freq,
    input wire [15:0] freq_cmd,
    input wire [1:0]  freq_source,
    input wire        multi_speed_active,
    input wire        remote_accel
);
    // ==========================================================
    // Outputs trail reset release by three edges, so $past is trusted after that
    reg  [1:0] up_ff;
    wire       ok = (up_ff == 2'h3);
    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n)
            up_ff <= 2'h0;
        else if (!ok)
            up_ff <= up_ff + 2'h1;
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    // ==========================================================
    // Properties
    property p_jog; ok && $past(jog_active) |-> freq_source == 2'h0; endproperty
    a_jog: assert property (p_jog) else $error("jog lost");
    property p_jogf; freq_source == 2'h0 |-> freq_cmd == $past(jog_freq); endproperty
    a_jogf: assert property (p_jogf) else $error("jog freq");
    property p_t4; ok && $past(term4_active) |-> freq_source != 2'h3; endproperty
    a_t4: assert property (p_t4) else $error("term4 lost");
    property p_t4f; freq_source == 2'h2 |-> freq_cmd == $past(term4_freq); endproperty
    a_t4f: assert property (p_t4f) else $error("term4 freq");
    property p_t2f; ok && freq_source == 2'h3 |-> freq_cmd == $past(term2_freq); endproperty
    a_t2f: assert property (p_t2f) else $error("term2 freq");
    property p_ms; multi_speed_active == (freq_source == 2'h1); endproperty
    a_ms: assert property (p_ms) else $error("multi flag");
    property p_rem; remote_accel |-> !multi_speed_active; endproperty
    a_rem: assert property (p_rem) else $error("remote with multi");
    property p_max; multi_speed_active |-> freq_cmd <= 16'h0FA0; endproperty
    a_max: assert property (p_max) else $error("freq range");
    property p_err; pslverr |-> psel && penable; endproperty
    a_err: assert property (p_err) else $error("pslverr outside access");
endmodule

// File: testbench/contact_bank.sv
// Contact switch bank in front of the selector's terminals.
// Assumes levels settle one edge after they are asked for.
`timescale 1ns/10ps
module contact_bank (
    // Clock and request
    input  wire        sys_clk,
    input  wire [11:0] want,
    // Contact levels
    output reg  [11:0] term_in
);
    // Debounced contacts only move at an edge
    always @(posedge sys_clk) term_in <= want;
endmodule

// File: testbench/multi_speed_frequency_selector_tb_top.sv
// Bench top: APB and contact stimulus, checks the frequency command.
// Assumes contact_bank and msfs_chk are compiled first.
`timescale 1ns/10ps
module multi_speed_frequency_selector_tb_top;
    logic        sys_clk, reset_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000, want = 12'h000, term_in;
    logic [31:0] pwdata = 32'h0, prdata, rd_q;
    logic        pready, pslverr, err_q, jog_active = 1'b0, term4_active = 1'b0;
    logic [15:0] jog_freq = 16'h0032, term4_freq = 16'h0555, term2_freq = 16'h0777, freq_cmd;
    logic [16:0] comp_offset = 17'h00000;
    logic [1:0]  freq_source;
    logic        multi_speed_active, remote_accel, remote_decel, remote_clear;
    int          n_fail = 0, checks_done = 0;
    multi_speed_frequency_selector u_dut (
        .sys_clk(sys_clk), .reset_n(reset_n), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .term_in(term_in), .jog_active(jog_active),
        .jog_freq(jog_freq), .term4_active(term4_active), .term4_freq(term4_freq),
        .term2_freq(term2_freq), .comp_offset(comp_offset), .freq_cmd(freq_cmd),
        .freq_source(freq_source), .multi_speed_active(multi_speed_active),
        .remote_accel(remote_accel), .remote_decel(remote_decel),
        .remote_clear(remote_clear));
    contact_bank u_contacts (.sys_clk(sys_clk), .want(want), .term_in(term_in));
    // ==========================================================
    // Clock, comparison and bus tasks
    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end
    task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            n_fail++;
            $display("CHECK FAILED %s exp %h got %h", nm, e, g);
        end
    endtask
    // Request held until pready is seen high at an edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        @(posedge sys_clk);
        while (pready !== 1'b1)
            @(posedge sys_clk);
        rd_q = prdata;
        err_q = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic e);
        apb(1'b1, a, d);
        cmp("pslverr", {31'h0, e}, {31'h0, err_q});
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        cmp("prdata", e, rd_q);
    endtask
    // Contacts take one edge, the selector one more
    task automatic sel(input logic [11:0] t, input logic [15:0] f, input logic [1:0] s);
        want <= t;
        repeat (3) @(posedge sys_clk);
        cmp("freq_cmd", {16'h0, f}, {16'h0, freq_cmd});
        cmp("freq_source", {30'h0, s}, {30'h0, freq_source});
    endtask
    // ==========================================================
    // Scenarios
    task automatic t_reset;
        rd(12'h040, 32'h0258);
        rd(12'h044, 32'h012C);
        rd(12'h048, 32'h0064);
        for (int i = 3; i < 15; i++)
            rd(12'h040 + 12'(4 * i), 32'h270F);
        wr(12'h07C, 32'h1, 1'b1);
        rd(12'h07C, 32'h0);
    endtask
    task automatic t_basic;
        sel(12'h004, 16'h0777, 2'h3);
        for (int m = 3; m < 5; m++) begin
            wr(12'h000, 32'(m), 1'b0);
            sel(12'h001, 16'h0064, 2'h1);
            sel(12'h002, 16'h012C, 2'h1);
            sel(12'h004, 16'h0258, 2'h1);
            sel(12'h006, 16'h012C, 2'h1);
            sel(12'h007, 16'h0064, 2'h1);
        end
    endtask
    task automatic t_ext;
        wr(12'h004, 32'h08020100, 1'b0);
        sel(12'h008, 16'h0064, 2'h1);
        wr(12'h05C, 32'h04D2, 1'b0);
        sel(12'h008, 16'h04D2, 2'h1);
        wr(12'h060, 32'h0100, 1'b0);
        sel(12'h009, 16'h0100, 2'h1);
        wr(12'h008, 32'hFFFF00FF, 1'b0);
        sel(12'h020, 16'h0064, 2'h1);
    endtask
    task automatic t_guard;
        wr(12'h000, 32'h00010003, 1'b0);
        wr(12'h064, 32'h0200, 1'b1);
        rd(12'h064, 32'h270F);
        wr(12'h048, 32'h00C8, 1'b0);
        sel(12'h001, 16'h00C8, 2'h1);
        wr(12'h000, 32'h0003, 1'b0);
        wr(12'h040, 32'h0FA1, 1'b1);
        wr(12'h040, 32'h0FA0, 1'b0);
        rd(12'h040, 32'h0FA0);
    endtask
    task automatic t_src;
        jog_active <= 1'b1;
        term4_active <= 1'b1;
        sel(12'h001, 16'h0032, 2'h0);
        jog_active <= 1'b0;
        sel(12'h001, 16'h00C8, 2'h1);
        sel(12'h000, 16'h0555, 2'h2);
        term4_active <= 1'b0;
        wr(12'h000, 32'h0103, 1'b0);
        comp_offset <= 17'h00014;
        sel(12'h001, 16'h00DC, 2'h1);
        comp_offset <= 17'h1FE00;
        sel(12'h002, 16'h0000, 2'h1);
        wr(12'h000, 32'h0003, 1'b0);
        sel(12'h004, 16'h0FA0, 2'h1);
        wr(12'h000, 32'h0013, 1'b0);
        sel(12'h004, 16'h0777, 2'h3);
        cmp("remote", 32'h4, {29'h0, remote_accel, remote_decel, remote_clear});
        sel(12'h003, 16'h0777, 2'h3);
        cmp("remote", 32'h3, {29'h0, remote_accel, remote_decel, remote_clear});
        rd(12'h01C, 32'h0777);
        rd(12'h018, 32'h0332);
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // ==========================================================
    // Main sequence and watchdog
    initial begin
        repeat (3) @(posedge sys_clk);
        reset_n <= 1'b1;
        repeat (3) @(posedge sys_clk);
        t_reset();
        t_basic();
        t_ext();
        t_guard();
        t_src();
        tally_and_finish();
    end
    initial begin
        #100000;
        n_fail++;
        tally_and_finish();
    end
endmodule
bind multi_speed_frequency_selector msfs_chk u_chk (
    .sys_clk(sys_clk), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pslverr(pslverr), .jog_active(jog_active), .jog_freq(jog_freq),
    .term4_active(term4_active), .term4_freq(term4_freq), .term2_freq(term2_freq),
    .freq_cmd(freq_cmd), .freq_source(freq_source),
    .multi_speed_active(multi_speed_active), .remote_accel(remote_accel));
